// ==== include/sem_defines.svh ====
`ifndef SEM_DEFINES_SVH
`define SEM_DEFINES_SVH

// clock rate and timing figures, times in their own unit
`define SEM_CLK_HZ 64'd200000000
`define SEM_GAP_MS 64'd20
`define SEM_BOOT_MS 64'd2900
`define SEM_CFG_MS 64'd3200
`define SEM_ESC_MIN_MS 64'd50
`define SEM_ESC_MAX_MS 64'd200
`define SEM_CMD_TO_S 64'd60
`define SEM_TICK_MS 64'd1

// derived cycle counts: least times round up, longest round down
`define SEM_GAP_CYC (`SEM_GAP_MS * `SEM_CLK_HZ / 64'd1000)
`define SEM_BOOT_CYC ((`SEM_BOOT_MS * `SEM_CLK_HZ + 64'd999) / 64'd1000)
`define SEM_CFG_CYC (`SEM_CFG_MS * `SEM_CLK_HZ / 64'd1000)
`define SEM_ESC_MIN_CYC ((`SEM_ESC_MIN_MS * `SEM_CLK_HZ + 64'd999) / 64'd1000)
`define SEM_ESC_MAX_CYC (`SEM_ESC_MAX_MS * `SEM_CLK_HZ / 64'd1000)
`define SEM_CMD_TO_CYC (`SEM_CMD_TO_S * `SEM_CLK_HZ)
`define SEM_TICK_CYC (`SEM_TICK_MS * `SEM_CLK_HZ / 64'd1000)

// register offsets
`define SEM_REG_CTRL 4'h0
`define SEM_REG_SLEEP 4'h4
`define SEM_REG_AWAKE 4'h8
`define SEM_REG_STATUS 4'hC

// control field positions
`define SEM_CTRL_API 0
`define SEM_CTRL_BAUD_LSB 1
`define SEM_CTRL_BAUD_MSB 3
`define SEM_CTRL_SLP_LSB 4
`define SEM_CTRL_SLP_MSB 5

// reset values
`define SEM_CTRL_RST 6'h08
`define SEM_TIME_RST 16'h0000

// baud codes and characters
`define SEM_BAUD_115200 3'h4
`define SEM_CHAR_PLUS 8'h2B
`define SEM_CHAR_O 8'h4F
`define SEM_CHAR_K 8'h4B

`endif

// ==== include/sem_pkg.sv ====
package sem_pkg;
  typedef enum {SEM_BOOT, SEM_CFG, SEM_RUN} sem_phase_t;
  typedef enum {SEM_TX_IDLE, SEM_TX_O, SEM_TX_K} sem_tx_t;
  typedef logic [39:0] sem_cnt_t;
endpackage : sem_pkg

// ==== include/sem_gap_if.sv ====
`timescale 1ns/1ps
interface sem_gap_if;
  logic byteSeen;
  logic [39:0] gapLimit;
  logic frameDone;
  logic frameOpen;
  modport owner (output byteSeen, output gapLimit, input frameDone,
                 input frameOpen);
  modport timer (input byteSeen, input gapLimit, output frameDone,
                 output frameOpen);
endinterface : sem_gap_if

// ==== hw/sem_gap_timer.sv ====
`timescale 1ns/1ps
module sem_gap_timer
  import sem_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  sem_gap_if.timer gap
);
  sem_cnt_t cnt_q;
  logic open_q;
  logic done_q;
  logic expire;

  // expiry only counts while a frame is open
  assign expire = open_q && !gap.byteSeen && (cnt_q + 40'h1 >= gap.gapLimit);

  // restart on each byte, close when idle reaches the limit
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cnt_q <= '0;
      open_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= expire;
      if (gap.byteSeen) begin
        cnt_q <= '0;
        open_q <= 1'b1;
      end else if (expire) begin
        cnt_q <= '0;
        open_q <= 1'b0;
      end else if (open_q) begin
        cnt_q <= cnt_q + 40'h1;
      end
    end
  end

  assign gap.frameDone = done_q;
  assign gap.frameOpen = open_q;
endmodule : sem_gap_timer

// ==== hw/sem_top.sv ====
// Contract
// - close packet after 20 ms idle at 115200
// - scale idle timeout with the chosen baud
// - ignore serial input for 2.9 s start-up
// - then 3.2 s transparent window at 115200
// - double plus string: answer OK, enter command
// - after window run preset mode, escape anytime
// - command mode times out after one minute
// - timer sleep never when both times zero
// - deep sleep follows sleep request level
`timescale 1ns/1ps
`include "sem_defines.svh"
module sem_top
  import sem_pkg::*;
#(
  parameter sem_cnt_t GAP_CYC = 40'(`SEM_GAP_CYC),
  parameter sem_cnt_t BOOT_CYC = 40'(`SEM_BOOT_CYC),
  parameter sem_cnt_t CFG_CYC = 40'(`SEM_CFG_CYC),
  parameter sem_cnt_t ESC_MIN_CYC = 40'(`SEM_ESC_MIN_CYC),
  parameter sem_cnt_t ESC_MAX_CYC = 40'(`SEM_ESC_MAX_CYC),
  parameter sem_cnt_t CMD_TO_CYC = 40'(`SEM_CMD_TO_CYC),
  parameter sem_cnt_t TICK_CYC = 40'(`SEM_TICK_CYC)
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  output logic txValid,
  output logic [7:0] txData,
  input wire logic txReady,
  output logic dataValid,
  output logic [7:0] dataByte,
  output logic frameEnd,
  output logic [2:0] baudSel,
  output logic cmdMode,
  output logic apiMode,
  input wire logic sleep_request_input,
  output logic sleepActive
);
  // parameters the counters cannot serve
  if (GAP_CYC < 40'h2 || TICK_CYC < 40'h1 || BOOT_CYC < 40'h1 ||
      CFG_CYC < 40'h1 || CMD_TO_CYC < 40'h1 ||
      ESC_MIN_CYC > ESC_MAX_CYC) begin : gBadParam
    $error("sem_top: illegal timing parameters");
  end

  // half-units of the 115200 gap for each baud code
  function automatic logic [4:0] semGapScale(input logic [2:0] code);
    unique case (code)
      3'h0: semGapScale = 5'h18; // 9600
      3'h1: semGapScale = 5'h0C; // 19200
      3'h2: semGapScale = 5'h06; // 38400
      3'h3: semGapScale = 5'h04; // 57600
      3'h4: semGapScale = 5'h02; // 115200
      3'h5: semGapScale = 5'h01; // 230400
      default: semGapScale = 5'h02; // unused codes act as 115200
    endcase
  endfunction : semGapScale

  sem_gap_if gap ();

  sem_phase_t phase_q;
  sem_tx_t txState_q;
  sem_cnt_t phaseCnt_q;
  sem_cnt_t escCnt_q;
  sem_cnt_t cmdCnt_q;
  sem_cnt_t tickCnt_q;
  logic [5:0] ctrl_q;
  logic [15:0] sleepTime_q;
  logic [15:0] awakeTime_q;
  logic [15:0] slpCnt_q;
  logic slpPhase_q;
  logic [1:0] plusRun_q;
  logic escArmed_q;
  logic cmdActive_q;
  logic [31:0] regRdata_q;
  logic dataValid_q;
  logic [7:0] dataByte_q;
  logic [7:0] txData_q;

  // register decode
  logic wrCtrl;
  logic wrSleep;
  logic wrAwake;
  logic [31:0] rdMux;
  logic [31:0] statusWord;
  assign wrCtrl = regWr && (regAddr == `SEM_REG_CTRL);
  assign wrSleep = regWr && (regAddr == `SEM_REG_SLEEP);
  assign wrAwake = regWr && (regAddr == `SEM_REG_AWAKE);
  assign statusWord = {24'h0, sleepActive, gap.frameOpen, cmdActive_q,
                       phase_q == SEM_CFG, phase_q == SEM_RUN, baudSel};
  assign rdMux = (regAddr == `SEM_REG_CTRL) ? {26'h0, ctrl_q} :
                 (regAddr == `SEM_REG_SLEEP) ? {16'h0, sleepTime_q} :
                 (regAddr == `SEM_REG_AWAKE) ? {16'h0, awakeTime_q} :
                 (regAddr == `SEM_REG_STATUS) ? statusWord : 32'h0;

  // effective serial setup: fixed until start-up and window are over
  logic [2:0] presetBaud;
  logic [1:0] slpSel;
  logic inRun;
  assign presetBaud = ctrl_q[`SEM_CTRL_BAUD_MSB:`SEM_CTRL_BAUD_LSB];
  assign slpSel = ctrl_q[`SEM_CTRL_SLP_MSB:`SEM_CTRL_SLP_LSB];
  assign inRun = (phase_q == SEM_RUN);
  assign baudSel = inRun ? presetBaud : `SEM_BAUD_115200;
  assign apiMode = inRun && !cmdActive_q && ctrl_q[`SEM_CTRL_API];
  assign cmdMode = cmdActive_q;

  // idle limit follows the effective baud
  logic [44:0] gapProd;
  assign gapProd = 45'(GAP_CYC) * 45'(semGapScale(baudSel));
  assign gap.gapLimit = gapProd[40:1];

  // bytes are dropped outright while booting
  logic rxTake;
  logic isPlus;
  logic plusDone;
  logic escInWin;
  logic escDouble;
  assign rxTake = rxValid && (phase_q != SEM_BOOT);
  assign gap.byteSeen = rxTake;
  assign isPlus = (rxData == `SEM_CHAR_PLUS);
  assign plusDone = rxTake && isPlus && (plusRun_q == 2'h2) && !cmdActive_q;
  assign escInWin = (escCnt_q >= ESC_MIN_CYC) && (escCnt_q <= ESC_MAX_CYC);
  assign escDouble = plusDone && escArmed_q && escInWin;

  logic phaseEnd;
  assign phaseEnd = (phaseCnt_q + 40'h1 >= (phase_q == SEM_BOOT ?
                                            BOOT_CYC : CFG_CYC));

  logic okDone;
  assign okDone = (txState_q == SEM_TX_K) && txReady;

  logic tick;
  assign tick = (tickCnt_q + 40'h1 >= TICK_CYC);

  // software registers
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctrl_q <= `SEM_CTRL_RST;
      sleepTime_q <= `SEM_TIME_RST;
      awakeTime_q <= `SEM_TIME_RST;
      regRdata_q <= 32'h0;
    end else begin
      if (wrCtrl) ctrl_q <= regWdata[5:0];
      if (wrSleep) sleepTime_q <= regWdata[15:0];
      if (wrAwake) awakeTime_q <= regWdata[15:0];
      regRdata_q <= regRd ? rdMux : 32'h0;
    end
  end

  // power-on phases: silent start-up, config window, then run
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      phase_q <= SEM_BOOT;
      phaseCnt_q <= '0;
    end else if (!inRun) begin
      phaseCnt_q <= phaseEnd ? '0 : phaseCnt_q + 40'h1;
      if (phaseEnd) begin
        unique case (phase_q)
          SEM_BOOT: phase_q <= SEM_CFG;
          SEM_CFG: phase_q <= SEM_RUN;
          SEM_RUN: phase_q <= SEM_RUN;
        endcase
      end
    end
  end

  // escape detector; a stray byte disarms, so payload must avoid it
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      plusRun_q <= 2'h0;
      escArmed_q <= 1'b0;
      escCnt_q <= '0;
    end else begin
      if (rxTake) begin
        plusRun_q <= (isPlus && plusRun_q != 2'h2) ? plusRun_q + 2'h1 :
                     2'h0;
      end
      if (plusDone) begin
        escArmed_q <= !escDouble;
        escCnt_q <= '0;
      end else if (rxTake && !isPlus) begin
        escArmed_q <= 1'b0;
      end else if (escArmed_q) begin
        escArmed_q <= (escCnt_q < ESC_MAX_CYC);
        escCnt_q <= escCnt_q + 40'h1;
      end
    end
  end

  // answer OK, then switch; the switch waits for the K to leave
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      txState_q <= SEM_TX_IDLE;
      txData_q <= 8'h00;
    end else begin
      unique case (txState_q)
        SEM_TX_IDLE: if (escDouble) begin
          txState_q <= SEM_TX_O;
          txData_q <= `SEM_CHAR_O;
        end
        SEM_TX_O: if (txReady) begin
          txState_q <= SEM_TX_K;
          txData_q <= `SEM_CHAR_K;
        end
        SEM_TX_K: if (txReady) begin
          txState_q <= SEM_TX_IDLE;
          txData_q <= 8'h00;
        end
      endcase
    end
  end
  assign txValid = (txState_q != SEM_TX_IDLE);
  assign txData = txData_q;

  // command mode with its one-minute silence timeout
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cmdActive_q <= 1'b0;
      cmdCnt_q <= '0;
    end else if (okDone) begin
      cmdActive_q <= 1'b1;
      cmdCnt_q <= '0;
    end else if (cmdActive_q) begin
      if (gap.frameDone) begin
        cmdCnt_q <= '0; // each command restarts the wait
      end else if (cmdCnt_q + 40'h1 >= CMD_TO_CYC) begin
        cmdActive_q <= 1'b0;
        cmdCnt_q <= '0;
      end else begin
        cmdCnt_q <= cmdCnt_q + 40'h1;
      end
    end
  end

  // forward accepted bytes to the data side outside command mode
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      dataValid_q <= 1'b0;
      dataByte_q <= 8'h00;
    end else begin
      dataValid_q <= rxTake && !cmdActive_q;
      if (rxTake) dataByte_q <= rxData;
    end
  end
  assign dataValid = dataValid_q;
  assign dataByte = dataByte_q;
  assign frameEnd = gap.frameDone;
  assign regRdata = regRdata_q;

  // millisecond tick for the sleep timer
  always_ff @(posedge mclk) begin
    if (!rst_b) tickCnt_q <= '0;
    else tickCnt_q <= tick ? '0 : tickCnt_q + 40'h1;
  end

  // timer sleep alternates awake and sleep spans
  logic bothZero;
  logic [15:0] spanLen;
  assign bothZero = (sleepTime_q == 16'h0) && (awakeTime_q == 16'h0);
  assign spanLen = slpPhase_q ? sleepTime_q : awakeTime_q;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      slpPhase_q <= 1'b0;
      slpCnt_q <= 16'h0;
    end else if (bothZero || slpSel != 2'h1 || !inRun) begin
      slpPhase_q <= 1'b0;
      slpCnt_q <= 16'h0;
    end else if (tick) begin
      if (slpCnt_q + 16'h1 >= spanLen) begin
        slpCnt_q <= 16'h0;
        // a zero sleep span keeps the part awake
        slpPhase_q <= !slpPhase_q && (sleepTime_q != 16'h0);
      end else begin
        slpCnt_q <= slpCnt_q + 16'h1;
      end
    end
  end

  // deep sleep simply follows the host level
  assign sleepActive = inRun && (
    (slpSel == 2'h2) ? sleep_request_input :
    (slpSel == 2'h1) ? (slpPhase_q && !bothZero) : 1'b0);

  sem_gap_timer uGap (
    .mclk(mclk),
    .rst_b(rst_b),
    .gap(gap)
  );
endmodule : sem_top

// ==== dv/sem_top_monitor.sv ====
`timescale 1ns/1ps
module sem_top_monitor
  import sem_pkg::*;
#(
  parameter sem_cnt_t GAP_CYC = 40'h28,
  parameter sem_cnt_t BOOT_CYC = 40'h32,
  parameter sem_cnt_t CFG_CYC = 40'h3C,
  parameter sem_cnt_t CMD_TO_CYC = 40'hC8
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txReady,
  input wire logic dataValid,
  input wire logic [7:0] dataByte,
  input wire logic frameEnd,
  input wire logic [2:0] baudSel,
  input wire logic cmdMode,
  input wire logic apiMode,
  input wire logic sleepActive
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sem_cnt_t upCnt_q, idle_q, cmdAge_q, lim;
  logic armed_q, booted, early, preRun;
  // idle limit scales with the effective baud code
  assign lim = (baudSel == 3'h0) ? GAP_CYC * 40'hC :
    (baudSel == 3'h1) ? GAP_CYC * 40'h6 : (baudSel == 3'h2) ? GAP_CYC * 40'h3 :
    (baudSel == 3'h3) ? GAP_CYC * 40'h2 :
    (baudSel == 3'h5) ? GAP_CYC / 40'h2 : GAP_CYC; // spare codes as 115200
  // margins keep phase edges out of the checks
  assign booted = upCnt_q > BOOT_CYC + 40'h2;
  assign early = upCnt_q + 40'h2 < BOOT_CYC;
  assign preRun = upCnt_q + 40'h2 < BOOT_CYC + CFG_CYC;
  // age since reset, since last byte, since cmd entry or last frame close in cmd mode
  always_ff @(posedge mclk) begin
    upCnt_q <= rst_b ? upCnt_q + 40'h1 : 40'h0;
    idle_q <= rxValid ? 40'h1 : idle_q + 40'h1;
    armed_q <= !rst_b ? 1'b0 : (rxValid && booted) ? 1'b1 :
      frameEnd ? 1'b0 : armed_q;
    cmdAge_q <= (!cmdMode || frameEnd) ? 40'h0 : cmdAge_q + 40'h1;
  end
  a_boot_quiet: assert property (early |-> !dataValid && !txValid)
    else $error("output active during start-up");
  a_cfg_fixed: assert property (preRun |-> baudSel == 3'h4 && !apiMode
    && !sleepActive) else $error("config window not fixed");
  a_byte_fwd: assert property (rxValid && booted && !cmdMode |=>
    dataValid && dataByte == $past(rxData)) else $error("byte lost");
  a_gap_close: assert property (frameEnd |-> idle_q == lim + 40'h1)
    else $error("frame closed at wrong gap");
  a_gap_due: assert property (armed_q && idle_q == lim + 40'h1
    |-> frameEnd) else $error("frame not closed");
  a_ok_first: assert property ($rose(txValid) |-> txData == 8'h4F)
    else $error("reply not starting with O");
  a_tx_hold: assert property (txValid && !txReady |=>
    txValid && $stable(txData)) else $error("tx byte dropped");
  a_ok_then_k: assert property (txValid && txReady
    && txData == 8'h4F |=> txValid && txData == 8'h4B)
    else $error("K not after O");
  a_k_enter: assert property (txValid && txReady && txData == 8'h4B
    |=> cmdMode) else $error("no cmd mode after reply");
  a_cmd_bound: assert property (cmdMode |-> cmdAge_q <= CMD_TO_CYC + 40'h2)
    else $error("cmd mode overstays");
  a_cmd_early: assert property ($fell(cmdMode) |->
    $past(cmdAge_q) + 40'h3 >= CMD_TO_CYC) else $error("cmd mode left early");
  c_frame: cover property (frameEnd);
  c_enter: cover property (txValid && txReady && txData == 8'h4B);
  c_leave: cover property ($fell(cmdMode));
endmodule : sem_top_monitor

bind sem_top sem_top_monitor #(.GAP_CYC(GAP_CYC), .BOOT_CYC(BOOT_CYC),
  .CFG_CYC(CFG_CYC), .CMD_TO_CYC(CMD_TO_CYC)) u_sem_top_monitor (.mclk,
  .rst_b, .rxValid, .rxData, .txValid, .txData, .txReady, .dataValid,
  .dataByte, .frameEnd, .baudSel, .cmdMode, .apiMode, .sleepActive);

// ==== dv/sem_host_model.sv ====
`timescale 1ns/1ps
module sem_host_model (
  input wire logic mclk,
  input wire logic slow,
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic txReady
);
  logic [7:0] got[$];
  initial txReady = 1'b0;
  // a slow host only opens every other slot, to stretch the reply
  always @(posedge mclk) begin
    txReady <= slow ? !txReady : 1'b1;
    if (txValid && txReady) got.push_back(txData);
  end
endmodule : sem_host_model

// ==== dv/sem_top_bench.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin nCompared++; if ((g) !== (e)) begin errCount++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module sem_top_bench;
  logic mclk = 1'b0, rst_b = 1'b0, regWr = 1'b0, regRd = 1'b0, slow = 1'b0;
  logic rxValid = 1'b0, sleepReq = 1'b0, txValid, txReady, dataValid;
  logic frameEnd, cmdMode, apiMode, sleepActive;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0, regRdata;
  logic [7:0] rxData = 8'h0, txData, dataByte;
  logic [2:0] baudSel;
  int errCount = 0, nCompared = 0, cyc = 0, lastRx = 0, feAt = 0;
  int nDv = 0, nFrm = 0, k = 0;
  always #2.5 mclk = ~mclk;
  // short counts keep the run small; the checks reuse them
  localparam logic [39:0] GAP = 40'h28;
  localparam logic [39:0] BOOT = 40'h32;
  localparam logic [39:0] CFG = 40'h3C;
  localparam logic [39:0] ESC_MIN = 40'hA;
  localparam logic [39:0] ESC_MAX = 40'h28;
  localparam logic [39:0] CMD_TO = 40'hC8;
  localparam logic [39:0] TICK = 40'h5;
  sem_top #(.GAP_CYC(GAP), .BOOT_CYC(BOOT), .CFG_CYC(CFG),
    .ESC_MIN_CYC(ESC_MIN), .ESC_MAX_CYC(ESC_MAX), .CMD_TO_CYC(CMD_TO),
    .TICK_CYC(TICK)) u_sem_top (.mclk, .rst_b, .regAddr, .regWdata,
    .regWr, .regRd, .regRdata, .rxValid, .rxData, .txValid, .txData,
    .txReady, .dataValid, .dataByte, .frameEnd, .baudSel, .cmdMode,
    .apiMode, .sleep_request_input(sleepReq), .sleepActive);
  sem_host_model u_sem_host_model (.mclk, .slow, .txValid, .txData, .txReady);
  // cycle stamps of last byte and frame close
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (rxValid === 1'b1) lastRx <= cyc;
    if (frameEnd === 1'b1) begin
      feAt <= cyc;
      nFrm <= nFrm + 1;
    end
    if (dataValid === 1'b1) nDv <= nDv + 1;
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 `CHK("regRdata", e, regRdata)
  endtask : rd
  task automatic tx(input logic [7:0] b);
    @(posedge mclk);
    rxValid <= 1'b1;
    rxData <= b;
    @(posedge mclk);
    rxValid <= 1'b0;
  endtask : tx
  task automatic cntSlp(input int n);
    k = 0;
    repeat (n) begin
      @(posedge mclk);
      if (sleepActive === 1'b1) k++;
    end
  endtask : cntSlp
  task automatic tally_and_finish();
    if (errCount == 0 && nCompared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // hang guard, well past the longest expected run
  initial begin
    repeat (4000) @(posedge mclk);
    errCount++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    rd(4'h0, 32'h8);
    rd(4'h4, 32'h0);
    rd(4'h8, 32'h0);
    rd(4'h2, 32'h0);
    wr(4'h0, 32'h1);
    tx(8'h55);
    repeat (50) @(posedge mclk);
    `CHK("bootDrop", 32'h0, nDv)
    tx(8'hA5);
    @(posedge mclk);
    #1 `CHK("fwdByte", 8'hA5, dataByte)
    `CHK("cfgBaud", 3'h4, baudSel)
    `CHK("cfgApi", 1'b0, apiMode)
    repeat (60) @(posedge mclk);
    `CHK("runBaud", 3'h0, baudSel)
    `CHK("runApi", 1'b1, apiMode)
    `CHK("cfgFrames", 32'h1, nFrm)
    wr(4'h0, 32'h9);
    // gaps just under the limit keep one frame
    repeat (3) begin
      tx(8'h31);
      repeat (30) @(posedge mclk);
    end
    repeat (20) @(posedge mclk);
    `CHK("oneFrame", 32'h2, nFrm)
    `CHK("gap115k", GAP + 40'h1, feAt - lastRx)
    slow <= 1'b1;
    // two plus strings some 21 cycles apart
    repeat (2) begin
      repeat (3) tx(8'h2B);
      repeat (15) @(posedge mclk);
    end
    `CHK("cmdIn", 1'b1, cmdMode)
    `CHK("cmdApi", 1'b0, apiMode)
    `CHK("replyLen", 32'h2, u_sem_host_model.got.size())
    `CHK("replyO", 8'h4F, u_sem_host_model.got[0])
    `CHK("replyK", 8'h4B, u_sem_host_model.got[1])
    // status: frame of plus bytes still open, cmd, run, baud 115200
    rd(4'hC, 32'h6C);
    repeat (150) @(posedge mclk);
    `CHK("cmdHeld", 1'b1, cmdMode)
    repeat (120) @(posedge mclk);
    `CHK("cmdOut", 1'b0, cmdMode)
    `CHK("backApi", 1'b1, apiMode)
    wr(4'h0, 32'h0);
    tx(8'h31);
    repeat (500) @(posedge mclk);
    `CHK("gap9600", GAP * 40'hC + 40'h1, feAt - lastRx)
    wr(4'h0, 32'h28);
    sleepReq <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 `CHK("deepOn", 1'b1, sleepActive)
    @(posedge mclk);
    sleepReq <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 `CHK("deepOff", 1'b0, sleepActive)
    wr(4'h0, 32'h18);
    cntSlp(60);
    `CHK("zeroTimes", 32'h0, k)
    wr(4'h8, 32'h1);
    wr(4'h4, 32'h1);
    cntSlp(40);
    `CHK("timerSleep", 1'b1, k > 0)
    `CHK("timerWake", 1'b1, k < 40)
    tally_and_finish();
  end
endmodule : sem_top_bench
